// file: logic/digital_io_terminal_config.sv
// Digital input polarity and output function/force/polarity configuration.
// Assumes input terminals are asynchronous pins, while the function states and
// encoder pulses come from logic on clk_i. Registers are reached over a plain
// address/strobe port with read data one cycle after the read strobe.
//
// What this block does
// - Inputs three to ten each have a polarity bit; zero means low is asserted.
// - Pair source selects functions, encoder A/B, or Z on output one.
// - Readback shows six output states, bit zero for output one, set means on.
// - While forcing is active, the six-bit mask decides which outputs are on.
// - Mask bit zero drives output one, higher bits the following outputs.
// - Output one polarity bit, default zero, drives low when asserted.
// - Every setting is writable anytime and reaches the outputs one clock after the write.
// - Outputs two to six have polarity bits; zero active low, one active high.
module digital_io_terminal_config #(
	parameter int NUM_FUNC = dio_cfg_pkg::NUM_FUNC
) (
	// Clock and reset
	input  wire logic                    clk_i,
	input  wire logic                    rstn_i,
	// Register port
	input  wire logic [7:0]              reg_addr_i,
	input  wire logic [15:0]             reg_wdata_i,
	input  wire logic                    reg_write_i,
	input  wire logic                    reg_read_i,
	output logic      [15:0]             reg_rdata_o,
	// Input terminals (pins)
	input  wire logic                    input_terminal_3_i,
	input  wire logic                    input_terminal_4_i,
	input  wire logic                    input_terminal_5_i,
	input  wire logic                    input_terminal_6_i,
	input  wire logic                    input_terminal_7_i,
	input  wire logic                    input_terminal_8_i,
	input  wire logic                    input_terminal_9_i,
	input  wire logic                    input_terminal_10_i,
	// Asserted state of inputs three to ten, bit zero is input three
	output logic      [7:0]              input_asserted_o,
	// Drive function states and encoder pulses
	input  wire logic [NUM_FUNC-1:0]     function_state_i,
	input  wire logic                    encoder_a_i,
	input  wire logic                    encoder_b_i,
	input  wire logic                    encoder_z_i,
	// Output terminals
	output logic                         output_terminal_1_o,
	output logic                         output_terminal_2_o,
	output logic                         output_terminal_3_o,
	output logic                         output_terminal_4_o,
	output logic                         output_terminal_5_o,
	output logic                         output_terminal_6_o
);

	// Settings
	logic [7:0] in_pol;
	logic [5:0] out_pol;
	logic [1:0] pair_source;
	logic [6:0] out_func [dio_cfg_pkg::NUM_OUT];
	logic [5:0] force_mask;
	logic       force_enable;

	// Internal state
	logic [7:0]  in_level;
	logic [7:0]  in_raw;
	logic [5:0]  out_on;
	logic [5:0]  next_out_on;
	logic [15:0] next_rdata;

	// Word address match against a base plus an index
	function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] base, input int idx);
		addr_hit = (addr == 8'(base + 8'(idx)));
	endfunction

	// Function code to state; code zero and anything past the table are off
	function automatic logic func_pick(input logic [6:0] code, input logic [NUM_FUNC-1:0] states);
		func_pick = 1'b0;
		if (code != 7'h00 && int'(code) < NUM_FUNC) begin
			func_pick = states[code];
		end
	endfunction

	// Terminal level from logical state: polarity one is active high
	function automatic logic apply_pol(input logic state, input logic pol);
		apply_pol = pol ? state : ~state;
	endfunction

	assign in_raw = {input_terminal_10_i, input_terminal_9_i, input_terminal_8_i, input_terminal_7_i,
			input_terminal_6_i, input_terminal_5_i, input_terminal_4_i, input_terminal_3_i};

	pin_sync #(
		.WIDTH (dio_cfg_pkg::NUM_IN)
	) u_in_sync (
		.clk_i   (clk_i),
		.rstn_i  (rstn_i),
		.pins_i  (in_raw),
		.level_o (in_level)
	);

	// Input polarity settings
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			in_pol <= dio_cfg_pkg::IN_POL_RESET;
		end else if (reg_write_i) begin
			for (int i = 0; i < dio_cfg_pkg::NUM_IN; i++) begin
				if (addr_hit(reg_addr_i, dio_cfg_pkg::ADDR_IN_POL_BASE, i)) begin
					in_pol[i] <= reg_wdata_i[0];
				end
			end
		end
	end

	// Output polarity settings, output one first
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			out_pol <= dio_cfg_pkg::OUT_POL_RESET;
		end else if (reg_write_i) begin
			for (int i = 0; i < dio_cfg_pkg::NUM_OUT; i++) begin
				if (addr_hit(reg_addr_i, dio_cfg_pkg::ADDR_OUT_POL_BASE, i)) begin
					out_pol[i] <= reg_wdata_i[0];
				end
			end
		end
	end

	// Pair source; out-of-range codes leave the setting unchanged
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pair_source <= dio_cfg_pkg::PAIR_SRC_RESET;
		end else if (reg_write_i && reg_addr_i == dio_cfg_pkg::ADDR_PAIR_SOURCE) begin
			if (reg_wdata_i <= 16'(dio_cfg_pkg::PAIR_SOURCE_MAX)) begin
				pair_source <= reg_wdata_i[1:0];
			end
		end
	end

	// Function selectors; codes above 99 are rejected so no state is ever undefined
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			out_func[0] <= dio_cfg_pkg::OUT1_FUNC_RESET;
			out_func[1] <= dio_cfg_pkg::OUT2_FUNC_RESET;
			for (int i = 2; i < dio_cfg_pkg::NUM_OUT; i++) begin
				out_func[i] <= dio_cfg_pkg::OUTX_FUNC_RESET;
			end
		end else if (reg_write_i && reg_wdata_i <= 16'(dio_cfg_pkg::FUNC_CODE_MAX)) begin
			for (int i = 0; i < dio_cfg_pkg::NUM_OUT; i++) begin
				if (addr_hit(reg_addr_i, dio_cfg_pkg::ADDR_OUT_FUNC_BASE, i)) begin
					out_func[i] <= reg_wdata_i[6:0];
				end
			end
		end
	end

	// Force mask and force enable
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			force_mask   <= dio_cfg_pkg::FORCE_MASK_RESET;
			force_enable <= 1'b0;
		end else if (reg_write_i) begin
			if (reg_addr_i == dio_cfg_pkg::ADDR_FORCE_MASK) begin
				force_mask <= reg_wdata_i[5:0];
			end
			if (reg_addr_i == dio_cfg_pkg::ADDR_FORCE_CTRL) begin
				force_enable <= reg_wdata_i[0];
			end
		end
	end

	// Logical output state: force, then pair source, then function selectors
	always_comb begin
		for (int i = 0; i < dio_cfg_pkg::NUM_OUT; i++) begin
			next_out_on[i] = func_pick(out_func[i], function_state_i);
		end
		unique case (pair_source)
			dio_cfg_pkg::PAIR_ENCODER_AB: begin
				next_out_on[0] = encoder_a_i;
				next_out_on[1] = encoder_b_i;
			end
			dio_cfg_pkg::PAIR_INDEX_Z: begin
				next_out_on[0] = encoder_z_i;
			end
			default: begin
			end
		endcase
		if (force_enable) begin
			next_out_on = force_mask;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			out_on <= '0;
		end else begin
			out_on <= next_out_on;
		end
	end

	// Terminals take polarity from the same next state so they align with readback
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			output_terminal_1_o <= 1'b1;
			output_terminal_2_o <= 1'b1;
			output_terminal_3_o <= 1'b1;
			output_terminal_4_o <= 1'b1;
			output_terminal_5_o <= 1'b1;
			output_terminal_6_o <= 1'b1;
		end else begin
			output_terminal_1_o <= apply_pol(next_out_on[0], out_pol[0]);
			output_terminal_2_o <= apply_pol(next_out_on[1], out_pol[1]);
			output_terminal_3_o <= apply_pol(next_out_on[2], out_pol[2]);
			output_terminal_4_o <= apply_pol(next_out_on[3], out_pol[3]);
			output_terminal_5_o <= apply_pol(next_out_on[4], out_pol[4]);
			output_terminal_6_o <= apply_pol(next_out_on[5], out_pol[5]);
		end
	end

	// Input asserted state: polarity zero means a low terminal is asserted
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			input_asserted_o <= '0;
		end else begin
			input_asserted_o <= ~(in_level ^ in_pol);
		end
	end

	// Read mux
	always_comb begin
		next_rdata = 16'h0000;
		for (int i = 0; i < dio_cfg_pkg::NUM_IN; i++) begin
			if (addr_hit(reg_addr_i, dio_cfg_pkg::ADDR_IN_POL_BASE, i)) begin
				next_rdata = {15'h0000, in_pol[i]};
			end
		end
		for (int i = 0; i < dio_cfg_pkg::NUM_OUT; i++) begin
			if (addr_hit(reg_addr_i, dio_cfg_pkg::ADDR_OUT_FUNC_BASE, i)) begin
				next_rdata = {9'h000, out_func[i]};
			end
			if (addr_hit(reg_addr_i, dio_cfg_pkg::ADDR_OUT_POL_BASE, i)) begin
				next_rdata = {15'h0000, out_pol[i]};
			end
		end
		unique case (reg_addr_i)
			dio_cfg_pkg::ADDR_PAIR_SOURCE:  next_rdata = {14'h0000, pair_source};
			dio_cfg_pkg::ADDR_OUT_READBACK: next_rdata = {10'h000, out_on};
			dio_cfg_pkg::ADDR_FORCE_MASK:   next_rdata = {10'h000, force_mask};
			dio_cfg_pkg::ADDR_FORCE_CTRL:   next_rdata = {15'h0000, force_enable};
			dio_cfg_pkg::ADDR_IN_STATE:     next_rdata = {8'h00, input_asserted_o};
			default: begin
			end
		endcase
	end

	// Read data stands only in the cycle after the read strobe
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			reg_rdata_o <= 16'h0000;
		end else if (reg_read_i) begin
			reg_rdata_o <= next_rdata;
		end else begin
			reg_rdata_o <= 16'h0000;
		end
	end

endmodule

// file: logic/dio_cfg_pkg.sv
// Package for the digital terminal configuration block: register map,
// field widths, reset values and encodings.
// Assumes a 250 MHz clock and a plain register port with 8-bit word addresses.
package dio_cfg_pkg;

	// Register port
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;

	// Terminal counts, function code width and function count
	localparam int NUM_IN  = 8;
	localparam int NUM_OUT = 6;
	localparam int FUNC_W  = 7;
	localparam int NUM_FUNC = 100;

	// Register word addresses
	localparam logic [7:0] ADDR_IN_POL_BASE   = 8'h17;
	localparam logic [7:0] ADDR_PAIR_SOURCE   = 8'h28;
	localparam logic [7:0] ADDR_OUT_FUNC_BASE = 8'h29;
	localparam logic [7:0] ADDR_OUT_READBACK  = 8'h31;
	localparam logic [7:0] ADDR_FORCE_MASK    = 8'h32;
	localparam logic [7:0] ADDR_OUT_POL_BASE  = 8'h33;
	localparam logic [7:0] ADDR_FORCE_CTRL    = 8'h3f;
	localparam logic [7:0] ADDR_IN_STATE      = 8'h0c;

	// Field limits
	localparam logic [6:0] FUNC_CODE_MAX   = 7'h63;
	localparam logic [1:0] PAIR_SOURCE_MAX = 2'h2;

	// Reset values
	localparam logic [6:0] OUT1_FUNC_RESET  = 7'h09;
	localparam logic [6:0] OUT2_FUNC_RESET  = 7'h0d;
	localparam logic [6:0] OUTX_FUNC_RESET  = 7'h00;
	localparam logic [7:0] IN_POL_RESET     = 8'h00;
	localparam logic [5:0] OUT_POL_RESET    = 6'h00;
	localparam logic [5:0] FORCE_MASK_RESET = 6'h00;
	localparam logic [1:0] PAIR_SRC_RESET   = 2'h0;

	// Output pair source modes
	typedef enum logic [1:0] {
		PAIR_FUNCTION,
		PAIR_ENCODER_AB,
		PAIR_INDEX_Z
	} pair_source_t;

endpackage

// file: logic/pin_sync.sv
// Three-stage synchroniser for pin inputs with agreement filter.
// Assumes the inputs are asynchronous to clk_i; the held value changes only
// once the second and third stages agree.
module pin_sync #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rstn_i,
	// Raw pins and filtered levels
	input  wire logic [WIDTH-1:0] pins_i,
	output logic      [WIDTH-1:0] level_o
);

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	// First stage feeds only the second stage
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end else begin
			stage1 <= pins_i;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			level_o <= '0;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (stage2[i] == stage3[i]) begin
					level_o[i] <= stage3[i];
				end
			end
		end
	end

endmodule

// file: test/digital_io_terminal_config_test.sv
// Self-checking bench for the terminal configuration block.
// Assumes the checker and field wiring model are compiled before it.
module digital_io_terminal_config_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic                               clk_i = 0;
	logic                               rstn_i = 0;
	logic [7:0]                         addr = 0;
	logic [15:0]                        wdata = 0;
	logic                               wr = 0;
	logic                               rd = 0;
	logic [15:0]                        rdata;
	logic [7:0]                         lvl = 0;
	logic [7:0]                         pin;
	logic [7:0]                         asrt;
	logic [dio_cfg_pkg::NUM_FUNC-1:0]   fs = '0;
	logic                               ea = 0;
	logic                               eb = 0;
	logic                               ez = 0;
	logic [5:0]                         term;
	logic [5:0]                         seen;
	int                                 n_fail = 0;
	int                                 n_tests = 0;
	always #2 clk_i = ~clk_i;
	digital_io_terminal_config DUT (.clk_i, .rstn_i, .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_write_i(wr), .reg_read_i(rd), .reg_rdata_o(rdata), .input_terminal_3_i(pin[0]),
		.input_terminal_4_i(pin[1]), .input_terminal_5_i(pin[2]), .input_terminal_6_i(pin[3]),
		.input_terminal_7_i(pin[4]), .input_terminal_8_i(pin[5]), .input_terminal_9_i(pin[6]),
		.input_terminal_10_i(pin[7]), .input_asserted_o(asrt), .function_state_i(fs),
		.encoder_a_i(ea), .encoder_b_i(eb), .encoder_z_i(ez), .output_terminal_1_o(term[0]),
		.output_terminal_2_o(term[1]), .output_terminal_3_o(term[2]), .output_terminal_4_o(term[3]),
		.output_terminal_5_o(term[4]), .output_terminal_6_o(term[5]));
	field_io_model FIELD (.level_i(lvl), .seen_o(seen), .pin_o(pin), .term_i(term));
	task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] s);
		n_tests++;
		if (s !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wrr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_i);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask
	task automatic rdc(input string n, input logic [7:0] a, input logic [15:0] e);
		@(posedge clk_i);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk_i);
		rd <= 1'b0;
		#1 cmp(n, e, rdata);
	endtask
	// Outputs are registered once, so two edges cover any setting change
	task automatic pins(input string n, input logic [5:0] e);
		repeat (2) @(posedge clk_i);
		#1 cmp(n, {10'h0, e}, {10'h0, seen});
	endtask
	task automatic t_reset;
		cmp("term_rst", 16'h3f, {10'h0, seen});
		for (int i = 0; i < 6; i++) rdc("func", 8'h29 + 8'(i), i == 0 ? 16'h9 : i == 1 ? 16'hd : 16'h0);
		for (int i = 0; i < 8; i++) rdc("in_pol", 8'h17 + 8'(i), 16'h0);
		for (int i = 0; i < 6; i++) rdc("out_pol", 8'h33 + 8'(i), 16'h0);
		$display("t_reset done");
	endtask
	task automatic t_force;
		wrr(dio_cfg_pkg::ADDR_FORCE_MASK, 16'h2a);
		wrr(dio_cfg_pkg::ADDR_FORCE_CTRL, 16'h1);
		pins("force", 6'h15);
		rdc("readback", dio_cfg_pkg::ADDR_OUT_READBACK, 16'h2a);
		for (int i = 0; i < 6; i++) wrr(8'h33 + 8'(i), 16'h1);
		pins("force_pol", 6'h2a);
		wrr(dio_cfg_pkg::ADDR_OUT_READBACK, 16'h3);
		rdc("readback_pol", dio_cfg_pkg::ADDR_OUT_READBACK, 16'h2a);
		wrr(dio_cfg_pkg::ADDR_FORCE_CTRL, 16'h0);
		$display("t_force done");
	endtask
	task automatic t_pair;
		wrr(dio_cfg_pkg::ADDR_PAIR_SOURCE, 16'h1);
		ea <= 1'b1;
		pins("enc_a", 6'h01);
		@(posedge clk_i);
		ea <= 1'b0;
		eb <= 1'b1;
		pins("enc_b", 6'h02);
		wrr(dio_cfg_pkg::ADDR_PAIR_SOURCE, 16'h2);
		ez <= 1'b1;
		fs[13] <= 1'b1;
		pins("index", 6'h03);
		wrr(dio_cfg_pkg::ADDR_PAIR_SOURCE, 16'h3);
		rdc("pair_ref", dio_cfg_pkg::ADDR_PAIR_SOURCE, 16'h2);
		wrr(dio_cfg_pkg::ADDR_PAIR_SOURCE, 16'h0);
		pins("func_mode", 6'h02);
		$display("t_pair done");
	endtask
	task automatic t_func;
		wrr(8'h2b, 16'd99);
		fs[99] <= 1'b1;
		pins("func99", 6'h06);
		wrr(8'h2b, 16'd100);
		rdc("func_ref", 8'h2b, 16'd99);
		rdc("unmapped", 8'h00, 16'h0);
		$display("t_func done");
	endtask
	task automatic t_input;
		@(posedge clk_i);
		lvl <= 8'ha5;
		repeat (8) @(posedge clk_i);
		#1 cmp("in_low", 16'h5a, {8'h0, asrt});
		for (int i = 0; i < 8; i++) wrr(8'h17 + 8'(i), 16'h1);
		repeat (8) @(posedge clk_i);
		#1 cmp("in_high", 16'ha5, {8'h0, asrt});
		rdc("in_state", dio_cfg_pkg::ADDR_IN_STATE, 16'ha5);
		$display("t_input done");
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk_i);
		rstn_i <= 1'b1;
		t_reset;
		t_force;
		t_pair;
		t_func;
		t_input;
		wrap_up;
	end
	initial begin
		repeat (3000) @(posedge clk_i);
		n_fail++;
		wrap_up;
	end
endmodule
bind digital_io_terminal_config dio_cfg_chk CHK (.clk_i, .rstn_i, .reg_addr_i, .reg_wdata_i,
	.reg_write_i, .reg_read_i, .reg_rdata_o, .encoder_a_i, .encoder_b_i, .encoder_z_i,
	.output_terminal_1_o, .output_terminal_2_o, .output_terminal_3_o, .output_terminal_4_o,
	.output_terminal_5_o, .output_terminal_6_o);

// file: test/dio_cfg_chk.sv
// Checker for the terminal configuration block, bound to its top ports.
// Assumes one clock; shadows the force, pair source and output polarity settings from register writes.
module dio_cfg_chk (
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        rstn_i,
	// Register port
	input wire logic [7:0]  reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic        reg_write_i,
	input wire logic        reg_read_i,
	input wire logic [15:0] reg_rdata_o,
	// Encoder and terminals
	input wire logic        encoder_a_i,
	input wire logic        encoder_b_i,
	input wire logic        encoder_z_i,
	input wire logic        output_terminal_1_o,
	input wire logic        output_terminal_2_o,
	input wire logic        output_terminal_3_o,
	input wire logic        output_terminal_4_o,
	input wire logic        output_terminal_5_o,
	input wire logic        output_terminal_6_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	logic [5:0] term;
	logic [5:0] mask;
	logic [5:0] pol;
	logic [1:0] pair;
	logic       frc;
	logic [1:0] quiet;
	assign term = {output_terminal_6_o, output_terminal_5_o, output_terminal_4_o,
		output_terminal_3_o, output_terminal_2_o, output_terminal_1_o};
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mask <= '0;
			pol <= '0;
			pair <= '0;
			frc <= 1'b0;
		end else if (reg_write_i) begin
			if (reg_addr_i == dio_cfg_pkg::ADDR_FORCE_MASK) mask <= reg_wdata_i[5:0];
			if (reg_addr_i == dio_cfg_pkg::ADDR_FORCE_CTRL) frc <= reg_wdata_i[0];
			if (reg_addr_i == dio_cfg_pkg::ADDR_PAIR_SOURCE && reg_wdata_i <= 16'h2) pair <= reg_wdata_i[1:0];
			if (reg_addr_i >= 8'h33 && reg_addr_i <= 8'h38) pol[3'(reg_addr_i - 8'h33)] <= reg_wdata_i[0];
		end
	end
	// Outputs lag settings by one register, so judge only once writes rest
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) quiet <= '0;
		else if (reg_write_i) quiet <= '0;
		else if (quiet != 2'd3) quiet <= quiet + 2'd1;
	end
	sequence settled; quiet == 2'd3; endsequence
	sequence rb_read; reg_read_i && reg_addr_i == dio_cfg_pkg::ADDR_OUT_READBACK; endsequence
	sequence mask_read; reg_read_i && reg_addr_i == dio_cfg_pkg::ADDR_FORCE_MASK; endsequence
	force_drive_a: assert property (settled ##0 frc |-> term == (mask ~^ pol))
		else $error("forced terminals wrong");
	force_readback_a: assert property (rb_read ##0 settled ##0 frc |=> reg_rdata_o == {10'h0, mask})
		else $error("forced readback wrong");
	encoder_pair_a: assert property (settled ##0 (!frc && pair == 2'd1) |->
		term[1:0] == ({$past(encoder_b_i), $past(encoder_a_i)} ~^ pol[1:0]))
		else $error("encoder pair wrong");
	index_pulse_a: assert property (settled ##0 (!frc && pair == 2'd2) |->
		term[0] == ($past(encoder_z_i) ~^ pol[0]))
		else $error("index output wrong");
	func_range_a: assert property (reg_read_i && reg_addr_i inside {[8'h29:8'h2e]} |=> reg_rdata_o <= 16'h63)
		else $error("function code out of range");
	pair_read_a: assert property (reg_read_i && reg_addr_i == dio_cfg_pkg::ADDR_PAIR_SOURCE |=>
		reg_rdata_o == {14'h0, $past(pair)}) else $error("pair source read wrong");
	mask_read_a: assert property (mask_read |=> reg_rdata_o == {10'h0, $past(mask)})
		else $error("force mask read wrong");
	out1_pol_a: assert property (reg_read_i && reg_addr_i == 8'h33 |=> reg_rdata_o == {15'h0, $past(pol[0])})
		else $error("output one polarity read wrong");
endmodule

// file: test/field_io_model.sv
// Field wiring model: drives the input pins, watches the output terminals.
// Assumes the bench sets pin levels at clock edges.
module field_io_model (
	// Bench side
	input  wire logic [7:0] level_i,
	output logic      [5:0] seen_o,
	// Terminal side
	output logic      [7:0] pin_o,
	input  wire logic [5:0] term_i
);
	timeunit 1ns;
	timeprecision 1ps;
	// Push-pull contacts, so no pull levels to model
	assign pin_o  = level_i;
	assign seen_o = term_i;
endmodule
